// file: design/prt_timer.sv
/*
  Prescaled reload timer: 8-bit prescaler feeding an 8-bit main counter,
  with control/status bits and count write/read on plain ports.
  Assumes the oscillator and subclock arrive asynchronously and are
  sampled here; all logic runs on clk_i with asynchronous reset rst_i.
*/
`timescale 1ns/10ps
module prt_timer
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Asynchronous count source clocks
  input  wire logic       onchip_osc_clock_i,
  input  wire logic       subclock_i,
  // Control register write, one-cycle strobe
  input  wire logic       ctrl_wr_i,
  input  wire logic [7:0] ctrl_wdata_i,
  // Mode register write
  input  wire logic       mode_wr_i,
  input  wire logic [2:0] mode_wdata_i,
  input  wire logic [2:0] src_wdata_i,
  // Count register writes
  input  wire logic       pre_wr_i,
  input  wire logic       main_wr_i,
  input  wire logic [7:0] cnt_wdata_i,
  // Status and counts
  output logic      [7:0] ctrl_rdata_o,
  output logic      [2:0] mode_o,
  output logic      [7:0] prescale_count_o,
  output logic      [7:0] main_count_o,
  // Pin ownership and interrupt
  output logic            pin_owned_o,
  output logic            timer_irq_o
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [1:0] osc_sync;
    logic [1:0] sub_sync;
    logic       osc_prev;
    logic       sub_prev;
    logic [2:0] div8;
    logic [4:0] div32;
    logic       div2;
    logic       start;
    logic       cstf;
    logic       edgf;
    logic       undf;
    logic [2:0] mode;
    logic [2:0] src;
    logic [7:0] pre_rld;
    logic [7:0] pre_cnt;
    logic [7:0] main_rld;
    logic [7:0] main_cnt;
    logic       pre_pend;
    logic       main_pend;
    logic       irq;
  } prt_state_type;

  prt_state_type s_q;
  prt_state_type s_d;
  logic          tick;
  logic          pre_unf;
  logic          main_unf;

  // Selects the count source tick for a given select code
  function automatic logic src_tick(input logic [2:0] sel,
                                    input prt_state_type s,
                                    input logic osc_rise,
                                    input logic sub_tick);
    case (sel)
      prt_pkg::PRT_SRC_DIV1:  src_tick = 1'b1;
      prt_pkg::PRT_SRC_DIV2:  src_tick = s.div2;
      prt_pkg::PRT_SRC_DIV8:
        src_tick = (s.div8 == prt_pkg::PRT_DIV8_LAST);
      prt_pkg::PRT_SRC_OCO:   src_tick = osc_rise;
      prt_pkg::PRT_SRC_SUB32: src_tick = sub_tick;
      default:                src_tick = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next state

  // Single combinational update of the whole state record
  always_comb
  begin
    logic osc_rise;
    logic sub_rise;
    logic sub_tick;
    osc_rise = 1'b0;
    sub_rise = 1'b0;
    sub_tick = 1'b0;
    s_d      = s_q;
    // Oscillator and subclock pass two flops before edge detection
    s_d.osc_sync = {s_q.osc_sync[0], onchip_osc_clock_i};
    s_d.sub_sync = {s_q.sub_sync[0], subclock_i};
    s_d.osc_prev = s_q.osc_sync[1];
    s_d.sub_prev = s_q.sub_sync[1];
    osc_rise     = s_q.osc_sync[1] & ~s_q.osc_prev;
    sub_rise     = s_q.sub_sync[1] & ~s_q.sub_prev;
    s_d.div2 = ~s_q.div2;
    s_d.div8 = s_q.div8 + 3'h1;
    if (sub_rise)
    begin
      s_d.div32 = s_q.div32 + 5'h01;
    end
    sub_tick = sub_rise & (s_q.div32 == prt_pkg::PRT_DIV32_LAST);
    // status follows start on a source tick; a forced stop clears it at once
    tick = src_tick(s_q.src, s_q, osc_rise, sub_tick);
    if (tick)
    begin
      s_d.cstf = s_q.start;
    end
    pre_unf  = 1'b0;
    main_unf = 1'b0;
    s_d.irq  = 1'b0;
    // prescaler steps per source tick, main per prescaler underflow
    if (s_q.cstf && tick)
    begin
      if (s_q.pre_cnt == 8'h00 || s_q.pre_pend)
      begin
        // pending prescaler write lands on the source tick
        s_d.pre_cnt  = s_q.pre_rld;
        s_d.pre_pend = 1'b0;
        pre_unf      = (s_q.pre_cnt == 8'h00);
      end
      else
      begin
        s_d.pre_cnt = s_q.pre_cnt - 8'h01;
      end
      // main counter moves only on prescaler underflow
      if (pre_unf)
      begin
        // Pending main write lands here, no underflow unless at zero
        if (s_q.main_cnt == 8'h00 || s_q.main_pend)
        begin
          s_d.main_cnt  = s_q.main_rld;
          s_d.main_pend = 1'b0;
          main_unf      = (s_q.main_cnt == 8'h00);
        end
        else
        begin
          s_d.main_cnt = s_q.main_cnt - 8'h01;
        end
      end
    end
    // flags clear on zero written, one leaves them
    if (ctrl_wr_i)
    begin
      s_d.start = ctrl_wdata_i[prt_pkg::PRT_BIT_START];
      if (!ctrl_wdata_i[prt_pkg::PRT_BIT_EDGF])
      begin
        s_d.edgf = 1'b0;
      end
      if (!ctrl_wdata_i[prt_pkg::PRT_BIT_UNDF])
      begin
        s_d.undf = 1'b0;
      end
    end
    // underflow flag set wins over a same-cycle clear
    if (main_unf)
    begin
      s_d.undf = 1'b1;
      s_d.irq  = 1'b1;
    end
    // stopped writes hit reload and counter together
    if (pre_wr_i)
    begin
      s_d.pre_rld = cnt_wdata_i;
      if (!s_q.cstf)
      begin
        s_d.pre_cnt = cnt_wdata_i;
      end
      else
      begin
        s_d.pre_pend = 1'b1;
      end
    end
    if (main_wr_i)
    begin
      s_d.main_rld = cnt_wdata_i;
      if (!s_q.cstf)
      begin
        s_d.main_cnt = cnt_wdata_i;
      end
      else
      begin
        s_d.main_pend = 1'b1;
      end
    end
    // mode and source written only while idle, start and status both clear
    if (mode_wr_i && !s_q.start && !s_q.cstf)
    begin
      s_d.mode = mode_wdata_i;
      s_d.src  = src_wdata_i;
    end
    // forced stop returns counts and run bits to reset
    if (ctrl_wr_i && ctrl_wdata_i[prt_pkg::PRT_BIT_STOP])
    begin
      s_d.start    = 1'b0;
      s_d.cstf     = 1'b0;
      s_d.pre_cnt  = prt_pkg::PRT_CNT_RESET;
      s_d.pre_rld  = prt_pkg::PRT_CNT_RESET;
      s_d.main_cnt = prt_pkg::PRT_CNT_RESET;
      s_d.main_rld = prt_pkg::PRT_CNT_RESET;
      s_d.pre_pend = 1'b0;
      s_d.main_pend = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  // whole state registered on one clock
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_q          <= '0;
      s_q.pre_rld  <= prt_pkg::PRT_CNT_RESET;
      s_q.pre_cnt  <= prt_pkg::PRT_CNT_RESET;
      s_q.main_rld <= prt_pkg::PRT_CNT_RESET;
      s_q.main_cnt <= prt_pkg::PRT_CNT_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  // live counter values on the read ports
  always_comb
  begin
    ctrl_rdata_o = prt_pkg::PRT_CTL_RESET;
    ctrl_rdata_o[prt_pkg::PRT_BIT_START] = s_q.start;
    ctrl_rdata_o[prt_pkg::PRT_BIT_CSTF]  = s_q.cstf;
    ctrl_rdata_o[prt_pkg::PRT_BIT_EDGF]  = s_q.edgf;
    ctrl_rdata_o[prt_pkg::PRT_BIT_UNDF]  = s_q.undf;
  end
  assign mode_o           = s_q.mode;
  assign prescale_count_o = s_q.pre_cnt;
  assign main_count_o     = s_q.main_cnt;
  assign timer_irq_o      = s_q.irq;
  // timer mode never claims the shared pins
  assign pin_owned_o = (s_q.mode != prt_pkg::PRT_MODE_TIMER);

  ////////////////////////////////////////////////////////////////////////
  // Checks

  irq_sets_flag_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      timer_irq_o |-> s_q.undf)
    else $error("irq without underflow flag");

  force_stop_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      ctrl_wr_i && ctrl_wdata_i[prt_pkg::PRT_BIT_STOP] |=>
      main_count_o == 8'hFF && prescale_count_o == 8'hFF && !s_q.cstf)
    else $error("forced stop did not reset counts");

  flag_hold_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      !s_q.undf && !main_unf |=> !s_q.undf)
    else $error("underflow flag set without cause");

  stopped_load_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      pre_wr_i && !s_q.cstf && !ctrl_wr_i |=>
      prescale_count_o == $past(cnt_wdata_i))
    else $error("stopped prescaler write not loaded");

  main_hold_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      s_q.cstf && !pre_unf && !ctrl_wr_i && !main_wr_i |=>
      $stable(main_count_o))
    else $error("main counter moved without prescaler underflow");

  stop_halts_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      !s_q.cstf && !pre_wr_i && !ctrl_wr_i |=> $stable(prescale_count_o))
    else $error("prescaler moved while stopped");

  status_follow_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      tick && !ctrl_wr_i |=> s_q.cstf == $past(s_q.start))
    else $error("status flag did not follow start");

  main_reload_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      main_unf && !ctrl_wr_i |=> main_count_o == $past(s_q.main_rld))
    else $error("main counter did not reload");

  // every main underflow raises the request
  irq_on_unf_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      main_unf |=> timer_irq_o)
    else $error("main underflow without interrupt");

  // running prescaler waits for a tick
  pre_wait_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      s_q.cstf && !tick && !ctrl_wr_i |=> $stable(prescale_count_o))
    else $error("running prescaler moved off a source tick");

  // pending prescaler value lands on tick
  pre_land_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      s_q.cstf && tick && s_q.pre_pend && !ctrl_wr_i |=>
      prescale_count_o == $past(s_q.pre_rld))
    else $error("pending prescaler value not loaded");

  // pending main value lands on prescaler underflow
  main_land_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      pre_unf && s_q.main_pend && !ctrl_wr_i |=>
      main_count_o == $past(s_q.main_rld))
    else $error("pending main value not loaded");

endmodule

// file: design/prt_pkg.sv
/*
  Shared constants for the prescaled reload timer: control bit positions,
  mode codes, count source selects and reset values.
  Assumes a single 250 MHz clock and plain control ports, no register bus.
*/
package prt_pkg;

  // Mode register encodings
  typedef enum logic [2:0] {
    PRT_MODE_TIMER   = 3'h0,
    PRT_MODE_PULSE   = 3'h1,
    PRT_MODE_EVENT   = 3'h2,
    PRT_MODE_WIDTH   = 3'h3,
    PRT_MODE_PERIOD  = 3'h4
  } prt_mode_type;

  // Count source select encodings
  localparam logic [2:0] PRT_SRC_DIV1  = 3'h0;
  localparam logic [2:0] PRT_SRC_DIV8  = 3'h1;
  localparam logic [2:0] PRT_SRC_OCO   = 3'h2;
  localparam logic [2:0] PRT_SRC_DIV2  = 3'h3;
  localparam logic [2:0] PRT_SRC_SUB32 = 3'h4;

  // Control register bit positions
  localparam int PRT_BIT_START = 0;
  localparam int PRT_BIT_CSTF  = 1;
  localparam int PRT_BIT_STOP  = 2;
  localparam int PRT_BIT_EDGF  = 4;
  localparam int PRT_BIT_UNDF  = 5;

  // Values after reset
  localparam logic [7:0] PRT_CNT_RESET = 8'hFF;
  localparam logic [7:0] PRT_CTL_RESET = 8'h00;

  // Divider terminal counts for the system clock divide-by-8 and subclock divide-by-32 taps
  localparam logic [2:0] PRT_DIV8_LAST  = 3'h7;
  localparam logic [4:0] PRT_DIV32_LAST = 5'h1F;

endpackage

// file: dv/tb_prt_timer.sv
/*
  Self-checking bench for the prescaled reload timer in timer mode.
  Assumes the timer package is compiled first; ports are driven directly.
*/
`timescale 1ns/10ps
module tb_prt_timer;

  // Clocks, reset and design ports
  logic       clk_i              = 1'b0;
  logic       rst_i              = 1'b1;
  logic       onchip_osc_clock_i = 1'b0;
  logic       subclock_i         = 1'b0;
  logic       ctrl_wr_i          = 1'b0;
  logic [7:0] ctrl_wdata_i       = 8'h00;
  logic       mode_wr_i          = 1'b0;
  logic [2:0] mode_wdata_i       = 3'h0;
  logic [2:0] src_wdata_i        = 3'h0;
  logic       pre_wr_i           = 1'b0;
  logic       main_wr_i          = 1'b0;
  logic [7:0] cnt_wdata_i        = 8'h00;
  logic [7:0] ctrl_rdata_o;
  logic [2:0] mode_o;
  logic [7:0] prescale_count_o;
  logic [7:0] main_count_o;
  logic       pin_owned_o;
  logic       timer_irq_o;
  int         error_cnt          = 0;
  int         samples_checked    = 0;
  logic [7:0] held;

  prt_timer i_dut (
    .clk_i              (clk_i),
    .rst_i              (rst_i),
    .onchip_osc_clock_i (onchip_osc_clock_i),
    .subclock_i         (subclock_i),
    .ctrl_wr_i          (ctrl_wr_i),
    .ctrl_wdata_i       (ctrl_wdata_i),
    .mode_wr_i          (mode_wr_i),
    .mode_wdata_i       (mode_wdata_i),
    .src_wdata_i        (src_wdata_i),
    .pre_wr_i           (pre_wr_i),
    .main_wr_i          (main_wr_i),
    .cnt_wdata_i        (cnt_wdata_i),
    .ctrl_rdata_o       (ctrl_rdata_o),
    .mode_o             (mode_o),
    .prescale_count_o   (prescale_count_o),
    .main_count_o       (main_count_o),
    .pin_owned_o        (pin_owned_o),
    .timer_irq_o        (timer_irq_o)
  );

  ////////////////////////////////////////////////////////////////////////
  // Main clock, 4 ns period
  always #2 clk_i = ~clk_i;
  // Oscillator: exactly 6 main cycles, edges kept off the rising edge
  always #12 onchip_osc_clock_i = ~onchip_osc_clock_i;
  // Subclock: 2 main cycles, so one divided tick every 64 cycles
  always #4 subclock_i = ~subclock_i;

  ////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // One strobe: 0 control, 1 prescaler, 2 main, 3 mode
  task automatic wr(input int sel, input logic [7:0] d);
    @(negedge clk_i);
    ctrl_wdata_i = d;
    cnt_wdata_i  = d;
    ctrl_wr_i    = (sel == 0);
    pre_wr_i     = (sel == 1);
    main_wr_i    = (sel == 2);
    mode_wr_i    = (sel == 3);
    @(negedge clk_i);
    ctrl_wr_i    = 1'b0;
    pre_wr_i     = 1'b0;
    main_wr_i    = 1'b0;
    mode_wr_i    = 1'b0;
  endtask

  // Interrupt pulses seen over a window; a whole number of periods
  task automatic count_irq(input int win, input int exp_n, input string w);
    int k;
    k = 0;
    repeat (win) @(negedge clk_i) k += (timer_irq_o === 1'b1);
    check(w, 8'(k), 8'(exp_n));
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Load, start and time one source setting
  task automatic run_src(input logic [2:0] src, input logic [7:0] pre,
                         input logic [7:0] mn, input int win,
                         input int exp_n);
    wr(0, 8'h04);
    check("pre_after_stop", prescale_count_o, 8'hFF);
    check("main_after_stop", main_count_o, 8'hFF);
    wr(1, pre);
    wr(2, mn);
    check("pre_loaded", prescale_count_o, pre);
    check("main_loaded", main_count_o, mn);
    mode_wdata_i = prt_pkg::PRT_MODE_TIMER;
    src_wdata_i  = src;
    wr(3, 8'h00);
    // whole word, flags kept with ones
    wr(0, 8'h31);
    check("start_bit", {7'h00, ctrl_rdata_o[0]}, 8'h01);
    repeat (80) @(negedge clk_i);
    check("status_run", {7'h00, ctrl_rdata_o[1]}, 8'h01);
    count_irq(win, exp_n, "irq_count");
    check("undf_set", {7'h00, ctrl_rdata_o[5]}, 8'h01);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Watchdog, far beyond the few thousand cycles the run needs
  initial
  begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////
  // Scenarios

  // Outputs straight after the opening reset
  task automatic t_reset_values;
    check("rst_pre", prescale_count_o, 8'hFF);
    check("rst_ctrl", ctrl_rdata_o, 8'h00);
    check("rst_irq", {7'h00, timer_irq_o}, 8'h00);
  endtask

  // Every count source against its expected period
  task automatic t_sources;
    run_src(prt_pkg::PRT_SRC_DIV1, 8'h01, 8'h02, 60, 10);
    run_src(prt_pkg::PRT_SRC_DIV2, 8'h00, 8'h00, 48, 24);
    run_src(prt_pkg::PRT_SRC_DIV8, 8'h00, 8'h00, 48, 6);
    run_src(prt_pkg::PRT_SRC_OCO, 8'h00, 8'h01, 120, 10);
    run_src(prt_pkg::PRT_SRC_SUB32, 8'h00, 8'h00, 640, 10);
  endtask

  // Running prescaler write waits for the next source tick
  task automatic t_running_pre;
    int k;
    k = 0;
    run_src(prt_pkg::PRT_SRC_DIV8, 8'h03, 8'h00, 64, 2);
    wr(1, 8'h80);
    check("pre_not_yet", {7'h00, prescale_count_o == 8'h80}, 8'h00);
    // Ticks come every 8 cycles, so 9 is a safe bound
    while (prescale_count_o !== 8'h80 && k < 9)
    begin
      @(negedge clk_i);
      k++;
    end
    check("pre_on_tick", prescale_count_o, 8'h80);
    repeat (8) @(negedge clk_i);
    check("pre_next_tick", prescale_count_o, 8'h7F);
  endtask

  // Mode rewrite while running is ignored
  task automatic t_mode_refused;
    mode_wdata_i = prt_pkg::PRT_MODE_PULSE;
    wr(3, 8'h00);
    check("mode_refused", {5'h00, mode_o}, 8'h00);
  endtask

  // Plain stop, flags kept by writing ones
  task automatic t_plain_stop;
    wr(0, 8'h30);
    check("start_clr", {7'h00, ctrl_rdata_o[0]}, 8'h00);
    repeat (80) @(negedge clk_i);
    check("status_clr", {7'h00, ctrl_rdata_o[1]}, 8'h00);
    held = main_count_o;
    repeat (70) @(negedge clk_i);
    check("frozen", main_count_o, held);
    check("undf_kept", {7'h00, ctrl_rdata_o[5]}, 8'h01);
    wr(0, 8'h00);
    check("undf_clr", {7'h00, ctrl_rdata_o[5]}, 8'h00);
  endtask

  // Every mode accepted while fully stopped
  task automatic t_mode_set;
    for (int m = 4; m >= 0; m--)
    begin
      mode_wdata_i = 3'(m);
      wr(3, 8'h00);
      check("mode_set", {5'h00, mode_o}, 8'(m));
    end
    check("pins_free", {7'h00, pin_owned_o}, 8'h00);
  endtask

  // Running main write lands on the next prescaler underflow
  task automatic t_running_main;
    int k;
    k = 0;
    run_src(prt_pkg::PRT_SRC_DIV1, 8'h00, 8'h09, 100, 10);
    wr(2, 8'h00);
    repeat (30) @(negedge clk_i);
    count_irq(20, 20, "irq_reload");
    // Prescaler underflows every 4 cycles; main stays below 80h
    run_src(prt_pkg::PRT_SRC_DIV1, 8'h03, 8'h40, 260, 1);
    wr(2, 8'h80);
    check("main_not_yet", {7'h00, main_count_o == 8'h80}, 8'h00);
    while (main_count_o !== 8'h80 && k < 5)
    begin
      @(negedge clk_i);
      k++;
    end
    check("main_on_unf", main_count_o, 8'h80);
    repeat (4) @(negedge clk_i);
    check("main_next_unf", main_count_o, 8'h7F);
  endtask

  // Forced stop beats a same-cycle start
  task automatic t_force_stop;
    wr(0, 8'h05);
    check("force_ctrl", {6'h00, ctrl_rdata_o[1:0]}, 8'h00);
    check("force_main", main_count_o, 8'hFF);
  endtask

  // Reset in mid-run returns counts, control, mode and interrupt to reset values
  task automatic t_mid_reset;
    mode_wdata_i = prt_pkg::PRT_MODE_WIDTH;
    wr(3, 8'h00);
    wr(0, 8'h01);
    @(negedge clk_i);
    rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    check("mid_rst_pre", prescale_count_o, 8'hFF);
    check("mid_rst_main", main_count_o, 8'hFF);
    check("mid_rst_ctrl", ctrl_rdata_o, 8'h00);
    check("mid_rst_mode", {5'h00, mode_o}, 8'h00);
    check("mid_rst_irq", {7'h00, timer_irq_o}, 8'h00);
  endtask

  // Main sequence
  initial
  begin
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    t_reset_values();
    t_sources();
    t_running_pre();
    t_mode_refused();
    t_plain_stop();
    t_mode_set();
    t_running_main();
    t_force_stop();
    t_mid_reset();
    tally_and_finish();
  end

endmodule
